// file: rtl/tco_regs.svh
// Register offsets, field positions, reset values and sizes of the core
`ifndef TCO_REGS_SVH
`define TCO_REGS_SVH
`define TCO_A_INDIRECT 5'h00
`define TCO_A_TIMER 5'h01
`define TCO_A_PCL 5'h02
`define TCO_A_FLAGS 5'h03
`define TCO_A_FSP 5'h04
`define TCO_A_PORT1 5'h05
`define TCO_A_PORT2 5'h06
`define TCO_A_GP_LO 5'h07
`define TCO_A_GP_HI 5'h1f
`define TCO_F_C 0
`define TCO_F_DC 1
`define TCO_F_Z 2
`define TCO_F_PD 3
`define TCO_F_TO 4
`define TCO_F_WAKE 7
`define TCO_O_PSA 3
`define TCO_RST_PC 11'h7ff
`define TCO_RST_FLAGS 8'h98
`define TCO_RST_DIR 8'hff
`define TCO_RST_OPT 6'h3f
`define TCO_RST_OPT2 6'h3f
`define TCO_FSP_TOP 3'h7
`define TCO_STACK_DEPTH 2
`define TCO_SP_W 1
`define TCO_ID_WORDS 4
`define TCO_K_OPTION 5'h02
`define TCO_K_SLEEP 5'h03
`define TCO_K_WDT 5'h04
`define TCO_K_DIR1 5'h05
`define TCO_K_DIR2 5'h06
`define TCO_K_OPT2 5'h07
`endif

// file: rtl/tco_pkg.sv
// Types shared by the core and its surroundings
package tco_pkg;
    typedef enum logic [2:0] {
        TCO_RUN = 3'b001,
        TCO_BUBBLE = 3'b010,
        TCO_STANDBY = 3'b100
    } tco_state_t;
    typedef enum logic [1:0] {
        TCO_CAUSE_EXT = 2'h0,
        TCO_CAUSE_WDT = 2'h1,
        TCO_CAUSE_WAKE = 2'h2
    } tco_cause_t;
    typedef struct packed {
        logic valid;
        tco_cause_t cause;
    } tco_warm_t;
    typedef struct packed {
        logic we;
        logic [1:0] addr;
        logic [11:0] data;
    } tco_id_req_t;
endpackage

// file: rtl/tco_core.sv
// Instruction decode and execute core with 12-bit opcodes
`timescale 1ns/10ps
`include "tco_regs.svh"

// Notes on behaviour
// RULE_01 - Destination bit 0 sends result to accumulator, 1 to the file
// RULE_02 - dec_skip_zero writes decrement, skips on zero, no flags, one or two cycles
// RULE_03 - inc_skip_zero skips on zero result, no flags, one or two cycles
// RULE_04 - Rotates left or right through carry; only carry changes
// RULE_05 - or_acc_file ORs accumulator with file, updates zero only
// RULE_06 - xor_acc_file XORs accumulator with file, updates zero only
// RULE_07 - Bit ops: 3-bit index, 5-bit address; tests take two cycles on skip
// RULE_08 - or_literal and xor_literal update accumulator and zero flag
// RULE_09 - return_with_literal pops stack, loads literal, two cycles
// RULE_10 - Standby opcode enters standby, updates timeout, power-down, wake flags
// RULE_11 - Call pushes PC+1, loads literal, page bits from flags, PC8 zero
// RULE_12 - Call and PCL writes clear PC bit 8; return and unconditional_branch do not
// RULE_13 - Port read-modify-write uses sampled pin levels, not latches
// RULE_14 - direction_load_op 5 or 6 loads port direction; 1 means pin released
// RULE_15 - Writing timer_count clears prescaler when it belongs to timer
// RULE_16 - watchdog_clear_op clears watchdog, maybe prescaler, sets TO and PD
// RULE_17 - clear_file and clear_accumulator write zero and set zero flag
// RULE_18 - move_file updates zero flag from the moved value
// RULE_19 - store_acc_to_file copies accumulator, leaves all flags
// RULE_20 - Literal load into accumulator leaves flags untouched
// RULE_21 - General files are not reset and survive warm resets
// RULE_22 - Four ID words reachable only in program mode; upper bits ones (the core stores and returns all 12 bits as written)
// RULE_23 - Option load copies accumulator into 6-bit write-only config
// RULE_24 - Zero flag set on all-zero result of affecting ops, else cleared
// RULE_25 - A skipped instruction becomes one idle cycle with no effects
module tco_core (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [11:0] instr_i,
    output logic [10:0] pc_o,
    input wire tco_pkg::tco_warm_t warm_i,
    input wire logic prog_mode_i,
    input wire tco_pkg::tco_id_req_t id_req_i,
    output logic [11:0] id_data_o,
    input wire logic [3:0] pa_pins_i,
    output logic [3:0] pa_out_o,
    output logic [3:0] pa_oe_o,
    input wire logic [7:0] pb_pins_i,
    output logic [7:0] pb_out_o,
    output logic [7:0] pb_oe_o,
    output logic [5:0] option_o,
    output logic [5:0] extended_control_config_o,
    output logic presc_clr_o,
    output logic wdt_clr_o,
    output logic standby_o
);
    import tco_pkg::*;

    tco_state_t state;
    logic [10:0] pc;
    logic [7:0] w;
    logic [7:0] flags;
    logic [4:0] fsp;
    logic [7:0] tmr;
    logic [10:0] stack [0:`TCO_STACK_DEPTH-1];
    logic [`TCO_SP_W-1:0] sp;
    logic [7:0] gp [`TCO_A_GP_LO:`TCO_A_GP_HI];
    logic [11:0] ids [0:`TCO_ID_WORDS-1];
    logic [12:0] sync1;
    logic [12:0] sync2;
    logic [3:0] pa_q;
    logic [7:0] pb_q;
    logic prog_q;
    logic run;
    logic [10:0] pc_inc;
    logic [4:0] fa;
    logic [7:0] fval;
    logic [7:0] res;
    logic [7:0] k;
    logic [7:0] bmask;
    logic [8:0] sum;
    logic use_d;
    logic wr_f;
    logic wr_w;
    logic z_upd;
    logic c_upd;
    logic dc_upd;
    logic new_c;
    logic new_dc;
    logic skip;
    logic jump;
    logic [10:0] jtarget;
    logic push;
    logic pop;
    logic do_opt;
    logic do_sleep;
    logic do_wdt;
    logic do_dir;
    logic [7:0] next_flags;

    // Reads one file address; the port addresses return the pins
    function automatic logic [7:0] rd_file(input logic [4:0] a);
        if (a == `TCO_A_INDIRECT) begin
            rd_file = 8'h00;
        end else if (a == `TCO_A_TIMER) begin
            rd_file = tmr;
        end else if (a == `TCO_A_PCL) begin
            rd_file = pc[7:0];
        end else if (a == `TCO_A_FLAGS) begin
            rd_file = flags;
        end else if (a == `TCO_A_FSP) begin
            rd_file = {`TCO_FSP_TOP, fsp};
        end else if (a == `TCO_A_PORT1) begin
            rd_file = {4'h0, pa_q}; // RULE_13
        end else if (a == `TCO_A_PORT2) begin
            rd_file = pb_q; // RULE_13
        end else begin
            rd_file = gp[a];
        end
    endfunction

    // Two-stage synchroniser for pins and program mode strap
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1 <= 13'h0000;
            sync2 <= 13'h0000;
        end else if (ce_i) begin
            sync1 <= {prog_mode_i, pb_pins_i, pa_pins_i};
            sync2 <= sync1;
        end
    end
    assign pa_q = sync2[3:0];
    assign pb_q = sync2[11:4];
    assign prog_q = sync2[12];

    // Execution stalls in program mode so ID access cannot race it
    assign run = (state == TCO_RUN) && !prog_q;
    assign pc_inc = pc + 11'h001;
    assign fa = (instr_i[4:0] == `TCO_A_INDIRECT) ? fsp : instr_i[4:0];
    assign fval = rd_file(fa);
    assign k = instr_i[7:0];
    assign bmask = 8'h01 << instr_i[7:5];

    // Opcode decode and ALU
    always_comb begin
        res = 8'h00;
        sum = 9'h000;
        use_d = 1'b0;
        wr_f = 1'b0;
        wr_w = 1'b0;
        z_upd = 1'b0;
        c_upd = 1'b0;
        dc_upd = 1'b0;
        new_c = 1'b0;
        new_dc = 1'b0;
        skip = 1'b0;
        jump = 1'b0;
        jtarget = pc_inc;
        push = 1'b0;
        pop = 1'b0;
        do_opt = 1'b0;
        do_sleep = 1'b0;
        do_wdt = 1'b0;
        do_dir = 1'b0;
        if (instr_i[11:10] == 2'b00) begin
            case (instr_i[9:6])
                4'h0: begin
                    if (instr_i[5]) begin
                        res = w; // RULE_19
                        wr_f = 1'b1;
                    end else begin
                        do_opt = instr_i[4:0] == `TCO_K_OPTION;
                        do_sleep = instr_i[4:0] == `TCO_K_SLEEP;
                        do_wdt = instr_i[4:0] == `TCO_K_WDT;
                        do_dir = instr_i[4:0] >= `TCO_K_DIR1;
                    end
                end
                4'h1: begin
                    wr_f = instr_i[5]; // RULE_17
                    wr_w = !instr_i[5];
                    z_upd = 1'b1;
                end
                4'h2: begin
                    sum = {1'b0, fval} - {1'b0, w};
                    res = sum[7:0];
                    new_c = !sum[8]; // No borrow
                    new_dc = fval[3:0] >= w[3:0];
                    {use_d, z_upd, c_upd, dc_upd} = 4'hf;
                end
                4'h3: {res, use_d, z_upd} = {fval - 8'h01, 2'b11};
                4'h4: {res, use_d, z_upd} = {fval | w, 2'b11}; // RULE_05
                4'h5: {res, use_d, z_upd} = {fval & w, 2'b11};
                4'h6: {res, use_d, z_upd} = {fval ^ w, 2'b11}; // RULE_06
                4'h7: begin
                    sum = {1'b0, fval} + {1'b0, w};
                    res = sum[7:0];
                    new_c = sum[8];
                    new_dc = fval[3:0] > (4'hf - w[3:0]);
                    {use_d, z_upd, c_upd, dc_upd} = 4'hf;
                end
                4'h8: {res, use_d, z_upd} = {fval, 2'b11}; // RULE_18
                4'h9: {res, use_d, z_upd} = {~fval, 2'b11};
                4'ha: {res, use_d, z_upd} = {fval + 8'h01, 2'b11};
                4'hb: begin
                    res = fval - 8'h01;
                    use_d = 1'b1;
                    skip = res == 8'h00; // RULE_02
                end
                4'hc: begin
                    res = {flags[`TCO_F_C], fval[7:1]}; // RULE_04
                    new_c = fval[0];
                    {use_d, c_upd} = 2'b11;
                end
                4'hd: begin
                    res = {fval[6:0], flags[`TCO_F_C]}; // RULE_04
                    new_c = fval[7];
                    {use_d, c_upd} = 2'b11;
                end
                4'he: {res, use_d} = {fval[3:0], fval[7:4], 1'b1};
                default: begin
                    res = fval + 8'h01;
                    use_d = 1'b1;
                    skip = res == 8'h00; // RULE_03
                end
            endcase
        end else if (instr_i[11:10] == 2'b01) begin
            // Bit index in [7:5], file address in [4:0]
            case (instr_i[9:8])
                2'b00: {res, wr_f} = {fval & ~bmask, 1'b1}; // RULE_07
                2'b01: {res, wr_f} = {fval | bmask, 1'b1}; // RULE_07
                2'b10: skip = (fval & bmask) == 8'h00; // RULE_07
                default: skip = (fval & bmask) != 8'h00; // RULE_07
            endcase
        end else begin
            res = k;
            wr_w = 1'b1;
            case (instr_i[10:8])
                3'h0: begin
                    pop = 1'b1; // RULE_09
                    jump = 1'b1;
                    jtarget = stack[sp - `TCO_SP_W'(1)];
                end
                3'h1: begin
                    wr_w = 1'b0;
                    push = 1'b1; // RULE_11
                    jump = 1'b1;
                    jtarget = {flags[6:5], 1'b0, k}; // RULE_12
                end
                3'h2, 3'h3: begin
                    wr_w = 1'b0;
                    jump = 1'b1;
                    jtarget = {flags[6:5], instr_i[8:0]};
                end
                3'h4: res = k; // RULE_20
                3'h5: {res, z_upd} = {w | k, 1'b1}; // RULE_08
                3'h6: {res, z_upd} = {w & k, 1'b1};
                default: {res, z_upd} = {w ^ k, 1'b1}; // RULE_08
            endcase
        end
        if (use_d) begin
            wr_f = instr_i[5]; // RULE_01
            wr_w = !instr_i[5];
        end
        if (wr_f && fa == `TCO_A_PCL) begin
            jump = 1'b1;
            jtarget = {flags[6:5], 1'b0, res}; // RULE_12
        end
    end

    // Flag update; explicit flag writes come first, computed flags win
    always_comb begin
        next_flags = flags;
        if (wr_f && fa == `TCO_A_FLAGS) begin
            next_flags = {res[7:5], flags[4:3], res[2:0]};
        end
        if (z_upd) begin
            next_flags[`TCO_F_Z] = res == 8'h00; // RULE_24
        end
        if (c_upd) begin
            next_flags[`TCO_F_C] = new_c;
        end
        if (dc_upd) begin
            next_flags[`TCO_F_DC] = new_dc;
        end
        if (do_wdt) begin
            next_flags[`TCO_F_TO] = 1'b1; // RULE_16
            next_flags[`TCO_F_PD] = 1'b1;
        end
        if (do_sleep) begin
            next_flags[`TCO_F_TO] = 1'b1; // RULE_10
            next_flags[`TCO_F_PD] = 1'b0;
            next_flags[`TCO_F_WAKE] = 1'b0;
        end
    end

    // Sequencer: program counter, idle cycle and stack pointer
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= TCO_RUN;
            pc <= `TCO_RST_PC;
            sp <= '0;
        end else if (ce_i) begin
            if (warm_i.valid) begin
                state <= TCO_RUN;
                pc <= `TCO_RST_PC;
            end else begin
                case (state)
                    TCO_RUN: begin
                        if (!prog_q) begin
                            if (jump) begin
                                pc <= jtarget;
                                state <= TCO_BUBBLE;
                            end else if (skip) begin
                                pc <= pc + 11'h002; // RULE_25
                                state <= TCO_BUBBLE;
                            end else if (do_sleep) begin
                                pc <= pc_inc;
                                state <= TCO_STANDBY; // RULE_10
                            end else begin
                                pc <= pc_inc;
                            end
                            if (push) begin
                                sp <= sp + `TCO_SP_W'(1);
                            end else if (pop) begin
                                sp <= sp - `TCO_SP_W'(1);
                            end
                        end
                    end
                    TCO_BUBBLE: state <= TCO_RUN;
                    TCO_STANDBY: state <= TCO_STANDBY;
                    default: state <= TCO_RUN;
                endcase
            end
        end
    end

    // Return stack storage; wraps silently when overfilled
    always_ff @(posedge clk_i) begin
        if (ce_i && run && push && !warm_i.valid) begin
            stack[sp] <= pc_inc; // RULE_11
        end
    end

    // Accumulator keeps its value across warm resets
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            w <= 8'h00;
        end else if (ce_i && run && wr_w && !warm_i.valid) begin
            w <= res; // RULE_01
        end
    end

    // Status flags, with the per-cause warm reset values
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flags <= `TCO_RST_FLAGS;
        end else if (ce_i) begin
            if (warm_i.valid) begin
                flags[6:5] <= 2'b00;
                if (warm_i.cause == TCO_CAUSE_WDT) begin
                    flags[`TCO_F_TO] <= 1'b0;
                end
                if (warm_i.cause == TCO_CAUSE_WAKE) begin
                    flags[`TCO_F_WAKE] <= 1'b0;
                end
            end else if (run) begin
                flags <= next_flags;
            end
        end
    end

    // Special file registers, direction latches and configuration
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tmr <= 8'h00;
            fsp <= 5'h00;
            pa_out_o <= 4'h0;
            pb_out_o <= 8'h00;
            pa_oe_o <= 4'(~`TCO_RST_DIR); // Port A has only four pins
            pb_oe_o <= ~`TCO_RST_DIR;
            option_o <= `TCO_RST_OPT;
            extended_control_config_o <= `TCO_RST_OPT2;
        end else if (ce_i) begin
            if (warm_i.valid) begin
                pa_oe_o <= 4'(~`TCO_RST_DIR);
                pb_oe_o <= ~`TCO_RST_DIR;
                option_o <= `TCO_RST_OPT;
            end else if (run) begin
                if (wr_f) begin
                    if (fa == `TCO_A_TIMER) begin
                        tmr <= res;
                    end else if (fa == `TCO_A_FSP) begin
                        fsp <= res[4:0];
                    end else if (fa == `TCO_A_PORT1) begin
                        pa_out_o <= res[3:0];
                    end else if (fa == `TCO_A_PORT2) begin
                        pb_out_o <= res;
                    end
                end
                if (do_opt) begin
                    option_o <= w[5:0]; // RULE_23
                end
                if (do_dir && instr_i[4:0] == `TCO_K_DIR1) begin
                    pa_oe_o <= ~w[3:0]; // RULE_14
                end
                if (do_dir && instr_i[4:0] == `TCO_K_DIR2) begin
                    pb_oe_o <= ~w; // RULE_14
                end
                if (do_dir && instr_i[4:0] == `TCO_K_OPT2) begin
                    extended_control_config_o <= w[5:0];
                end
            end
        end
    end

    // General files carry no reset so that warm resets keep them
    always_ff @(posedge clk_i) begin
        if (ce_i && run && wr_f && !warm_i.valid && fa >= `TCO_A_GP_LO) begin
            gp[fa] <= res; // RULE_21
        end
    end

    // One-cycle side-effect strobes to timer and watchdog, and the registered standby level
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            presc_clr_o <= 1'b0;
            wdt_clr_o <= 1'b0;
            standby_o <= 1'b0;
        end else if (ce_i) begin
            presc_clr_o <= run && !warm_i.valid && ((wr_f && fa == `TCO_A_TIMER
                && !option_o[`TCO_O_PSA]) || (do_wdt && option_o[`TCO_O_PSA])); // RULE_15
            wdt_clr_o <= run && !warm_i.valid && do_wdt; // RULE_16
            standby_o <= !warm_i.valid && (state == TCO_STANDBY
                || (run && do_sleep && !jump && !skip));
        end
    end

    // ID words: only program mode can reach them
    always_ff @(posedge clk_i) begin
        if (ce_i && prog_q && id_req_i.we) begin
            ids[id_req_i.addr] <= id_req_i.data; // RULE_22
        end
    end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            id_data_o <= 12'h000;
        end else if (ce_i) begin
            id_data_o <= prog_q ? ids[id_req_i.addr] : 12'h000; // RULE_22
        end
    end

    assign pc_o = pc;

    sequence s_idle;
        state == TCO_BUBBLE;
    endsequence
    sequence s_resume;
        state == TCO_RUN;
    endsequence
    wire go = ce_i && run && !warm_i.valid;

    a_dest_acc: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RULE_01
        go && instr_i[11:5] == 7'h10 |=> w == $past(fval)) else $error("move_file to acc");
    a_dec_skip: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RULE_02
        go && instr_i[11:6] == 6'h0b && fval == 8'h01 |=> s_idle ##1 s_resume)
        else $error("dec skip timing");
    a_inc_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RULE_03
        go && instr_i[11:6] == 6'h0f |=> flags == $past(flags)) else $error("inc skip flags");
    a_rot_carry: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RULE_04
        go && instr_i[11:5] == 7'h1a |=> flags[0] == $past(fval[7]) && w[0] == $past(flags[0]))
        else $error("rotate left carry");
    a_or_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RULE_05
        go && instr_i[11:6] == 6'h04 && instr_i[4:0] != 5'h03 |=>
        flags[2] == ($past(fval | w) == 8'h00)) else $error("or zero flag");
    a_test_skip: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RULE_07
        go && instr_i[11:8] == 4'h7 && fval[instr_i[7:5]] |=> s_idle)
        else $error("test skip set");
    a_xor_lit: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RULE_08
        go && instr_i[11:8] == 4'hf |=> w == $past(w ^ k) && flags[2] == (w == 8'h00))
        else $error("xor literal");
    a_ret_lit: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RULE_09
        go && instr_i[11:8] == 4'h8 |=> w == $past(k) && pc == $past(jtarget) ##1 s_resume)
        else $error("return with literal");
    a_standby: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RULE_10
        go && instr_i == 12'h003 |=> standby_o && !flags[3] && flags[4])
        else $error("standby entry");
    a_call_page: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RULE_11
        go && instr_i[11:8] == 4'h9 |=> pc == {$past(flags[6:5]), 1'b0, $past(k)})
        else $error("call target");
    a_dir_load: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RULE_14
        go && instr_i == 12'h006 |=> pb_oe_o == ~$past(w)) else $error("direction load");
    a_presc_clr: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RULE_15
        go && wr_f && fa == 5'h01 && !option_o[3] |=> presc_clr_o) else $error("prescaler clear");
    a_wdt_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RULE_16
        go && instr_i == 12'h004 |=> wdt_clr_o && flags[4] && flags[3]) else $error("wdt clear");
    a_clr_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RULE_17
        go && instr_i == 12'h040 |=> w == 8'h00 && flags[2]) else $error("clear acc");
    a_lit_noflag: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RULE_20
        go && instr_i[11:8] == 4'hc |=> w == $past(k) && $stable(flags)) else $error("load lit");
    a_opt_load: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RULE_23
        go && instr_i == 12'h002 |=> option_o == $past(w[5:0])) else $error("option load");
    a_bubble_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RULE_25
        (s_idle and !warm_i.valid) |=> $stable(w) && $stable(flags)) else $error("idle cycle");
endmodule

// file: bench/tco_prog_mem.sv
// Program memory model that feeds twelve-bit opcodes to the core
`timescale 1ns/10ps
module tco_prog_mem (
    input wire logic [10:0] addr_i,
    output logic [11:0] instr_o
);
    logic [11:0] mem [0:2047];
    // Unwritten words read as no_operation, so a stray fetch does no harm
    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem[i] = 12'h000;
        end
    end
    // Read in the same cycle as the address, as the core expects
    assign instr_o = mem[addr_i];
endmodule

// file: bench/tb_twelve_bit_opcode_core_decoder.sv
// Self-checking testbench that runs a short program through the core
`timescale 1ns/10ps
module tb_twelve_bit_opcode_core_decoder;
    import tco_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] pb_pins_i = 8'h3c;
    logic [11:0] instr_i;
    logic [10:0] pc_o;
    logic [7:0] pb_out_o;
    logic [7:0] pb_oe_o;
    logic [5:0] option_o;
    logic wdt_clr_o;
    logic standby_o;
    logic presc_clr_o;
    logic [11:0] id_data_o;
    logic prog_mode_i = 1'b0;
    tco_warm_t warm_i = '0;
    tco_id_req_t id_req_i = '0;
    logic [11:0] prog [0:13] = '{12'hc01, 12'h027, 12'h2e7, 12'hcaa, 12'h006, 12'h206,
        12'h006, 12'hc5a, 12'hf5a, 12'h002, 12'h920, 12'h006, 12'h004, 12'h003};
    // Subroutine at 0x20: timer and port writes, rotate, or, clear, a taken bit test, return
    logic [11:0] sub [0:9] = '{12'h021, 12'hca5, 12'h026, 12'h347, 12'h107, 12'h040,
        12'h743, 12'hc99, 12'h3e7, 12'h833};
    int failures = 0;
    int total_checks = 0;
    // 10 MHz instruction clock
    always #50 clk_i = ~clk_i;
    tco_core u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .instr_i(instr_i),
        .pc_o(pc_o), .warm_i(warm_i), .prog_mode_i(prog_mode_i), .id_req_i(id_req_i),
        .id_data_o(id_data_o),
        .pa_pins_i(4'h0), .pa_out_o(), .pa_oe_o(), .pb_pins_i(pb_pins_i),
        .pb_out_o(pb_out_o), .pb_oe_o(pb_oe_o), .option_o(option_o), .extended_control_config_o(),
        .presc_clr_o(presc_clr_o), .wdt_clr_o(wdt_clr_o), .standby_o(standby_o));
    tco_prog_mem u_mem (.addr_i(pc_o), .instr_o(instr_i));
    // One comparison; four-state match so an unknown never passes
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for the fetch address, sampled clear of the edge
    task automatic wait_pc(input logic [10:0] p);
        for (int i = 0; i < 40 && pc_o !== p; i++) begin
            @(posedge clk_i);
            #2;
        end
        chk(pc_o, p);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Count reaches zero, so the load of 0xaa must be skipped
    task automatic t_skip();
        wait_pc(11'h005);
        chk(pb_oe_o, 11'h0fe);
        $display("skip test done");
    endtask
    // Port read takes the pin levels, not the latch
    task automatic t_pins();
        wait_pc(11'h007);
        chk(pb_oe_o, 11'h0c3);
        $display("pin read test done");
    endtask
    // Literal xor clears the accumulator, option load copies it
    task automatic t_option();
        wait_pc(11'h00a);
        chk(option_o, 11'h000);
        $display("option test done");
    endtask
    // Call lands with page bits zero, subroutine writes timer and port, return brings literal
    task automatic t_call();
        wait_pc(11'h020);
        wait_pc(11'h021);
        chk(presc_clr_o, 12'h001);
        wait_pc(11'h00b);
        wait_pc(11'h00c);
        chk(pb_oe_o, 11'h0cc);
        chk(pb_out_o, 12'h0a5);
        $display("call test done");
    endtask
    // Watchdog clear strobe, then standby entry
    task automatic t_standby();
        wait_pc(11'h00d);
        chk(wdt_clr_o, 11'h001);
        @(posedge clk_i);
        #2;
        chk(standby_o, 11'h001);
        $display("standby test done");
    endtask
    // Besides a system reset, a warm reset is the only way out of standby; it restores direction and option
    task automatic t_warm();
        warm_i.valid = 1'b1;
        @(posedge clk_i);
        #2;
        warm_i.valid = 1'b0;
        chk(pc_o, 12'h7ff);
        chk(standby_o, 12'h000);
        chk(pb_oe_o, 12'h000);
        chk(option_o, 12'h03f);
        $display("warm reset test done");
    endtask
    // ID word written and read back in program mode, hidden again outside it
    task automatic t_id();
        prog_mode_i = 1'b1;
        id_req_i = '{we: 1'b1, addr: 2'h1, data: 12'hff5};
        // Two edges through the synchroniser, one to write, one to read back
        repeat (4) @(posedge clk_i);
        #2;
        chk(id_data_o, 12'hff5);
        id_req_i.we = 1'b0;
        prog_mode_i = 1'b0;
        repeat (3) @(posedge clk_i);
        #2;
        chk(id_data_o, 12'h000);
        $display("id test done");
    endtask
    // Load the program, hold reset 8 cycles, then run the scenarios
    initial begin
        #1;
        u_mem.mem[11'h7ff] = 12'ha00;
        for (int i = 0; i < 14; i++) begin
            u_mem.mem[i] = prog[i];
        end
        for (int i = 0; i < 10; i++) begin
            u_mem.mem[32 + i] = sub[i];
        end
        repeat (8) @(posedge clk_i);
        #2;
        sys_rst_i = 1'b0;
        t_skip();
        t_pins();
        t_option();
        t_call();
        t_standby();
        t_warm();
        t_id();
        stop_test();
    end
    // Watchdog: the program needs well under 100 cycles
    initial begin
        #30000;
        failures++;
        stop_test();
    end
endmodule
